// File: src/ussmc_params.svh
// constants for the multi-rate sdi stream and mode control
`ifndef USSMC_PARAMS_SVH
`define USSMC_PARAMS_SVH
`define USSMC_WORD_W 10
`define USSMC_NSTREAM 16
`define USSMC_GT_W 40
`define USSMC_FIFO_DEPTH 32
`define USSMC_TRS_ONES 10'h3FF
`define USSMC_TRS_ZERO 10'h000
`define USSMC_NARROW_WORDS 2
`define USSMC_WIDE_WORDS 4
`define USSMC_NARROW_BITS 20
`define USSMC_SD_OVS 11
`define USSMC_SD_FRAME 110
`define USSMC_SD_PHASE 5
`define USSMC_CLK_MHZ 125
`define USSMC_GT_RST_NS 500
`define USSMC_GT_RST_CYC ((`USSMC_GT_RST_NS * `USSMC_CLK_MHZ + 999) / 1000)
`define USSMC_RATE_TICKS 16384
`define USSMC_RATE_TOL 8
`define USSMC_LINE_HD_MBPS 1485
`define USSMC_LINE_3G_MBPS 2970
`define USSMC_LINE_6G_MBPS 5940
`define USSMC_LINE_12G_MBPS 11880
`define USSMC_FRAC_DIV_PERMILLE 1001
`define USSMC_WCLK_SD_KHZ 148500
`define USSMC_WCLK_HD_KHZ 74250
`define USSMC_WCLK_3G_KHZ 148500
`define USSMC_WCLK_6G_KHZ 148500
`define USSMC_WCLK_12G_KHZ 297000
`define USSMC_DIV_12G 3'h0
`define USSMC_DIV_6G 3'h1
`define USSMC_DIV_3G 3'h2
`define USSMC_DIV_HD 3'h3
`endif

// File: src/ussmc_pkg.sv
// types and mode decoders shared by both ends
`include "ussmc_params.svh"
package ussmc_pkg;
  typedef enum logic [2:0] {
    USSMC_MODE_SD = 3'h0,
    USSMC_MODE_HD = 3'h1,
    USSMC_MODE_3GA = 3'h2,
    USSMC_MODE_3GB = 3'h3,
    USSMC_MODE_6G = 3'h4,
    USSMC_MODE_12G = 3'h5
  } ussmc_mode_t;

  typedef enum logic [2:0] {
    USSMC_MUX_1 = 3'h0,
    USSMC_MUX_2 = 3'h1,
    USSMC_MUX_4 = 3'h2,
    USSMC_MUX_8 = 3'h3,
    USSMC_MUX_16 = 3'h4
  } ussmc_mux_t;

  typedef logic [`USSMC_NSTREAM-1:0][`USSMC_WORD_W-1:0] ussmc_set_t;

  function automatic logic ussmc_is_wide(input ussmc_mode_t m);
    return (m == USSMC_MODE_6G) || (m == USSMC_MODE_12G);
  endfunction

  // serial divider code per mode; sd rides the 3g rate oversampled
  function automatic logic [2:0] ussmc_div(input ussmc_mode_t m);
    case (m)
      USSMC_MODE_HD: return `USSMC_DIV_HD;
      USSMC_MODE_6G: return `USSMC_DIV_6G;
      USSMC_MODE_12G: return `USSMC_DIV_12G;
      default: return `USSMC_DIV_3G;
    endcase
  endfunction

  function automatic logic [4:0] ussmc_nstreams(input ussmc_mux_t m);
    return 5'h01 << m;
  endfunction
endpackage

// File: src/ussmc_if.sv
// link between the device end and the user mapping end
interface ussmc_if import ussmc_pkg::*; ();
  ussmc_mode_t tx_mode;
  logic tx_frac;
  ussmc_mux_t tx_mux;
  ussmc_set_t tx_set;
  logic tx_valid;
  logic tx_ready;
  logic tx_ce;
  ussmc_mode_t rx_mode;
  ussmc_set_t rx_set;
  logic rx_valid;
  ussmc_mux_t rx_count;
  logic rx_frac;

  modport dev (
    input tx_mode, tx_frac, tx_mux, tx_set, tx_valid, rx_mode,
    output tx_ready, tx_ce, rx_set, rx_valid, rx_count, rx_frac
  );
  modport usr (
    output tx_mode, tx_frac, tx_mux, tx_set, tx_valid, rx_mode,
    input tx_ready, tx_ce, rx_set, rx_valid, rx_count, rx_frac
  );
endinterface

// File: src/ussmc_dev.sv
// device end: tx fifo, interleave, sd recovery, rx demux, rate detect, gt reset
`include "ussmc_params.svh"

module ussmc_fifo #(
  parameter int WIDTH = 160,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rp_r];
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      wp_r <= '0;
      rp_r <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      in_ready <= cnt_nxt != (AW+1)'(DEPTH);
      out_valid <= cnt_nxt != '0;
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end
endmodule

// Operation
// - gt word ports 20 or 40 bits
// - integer or fractional reference clock per mode
// - line rates 1.485, 2.97, 5.94, 11.88 Gb/s
// - receiver reports integer or fractional rate
// - sd data recovered by own oversampling unit
// - sequencer drives the transceiver reset
// - hd carries luma and chroma streams
// - 3g level a carries two streams
// - 3g level b interleaves four streams
// - sixteen numbered stream ports each way
// - user sees only elementary streams
// - sd is one elementary stream
// - user maps video to streams and back
// - one-to-one formats need no mapping
// - user maps dual, multi-link, 6g, 12g
// - 6g four or eight, 12g eight or sixteen
// - sixteen streams only for dual-link 12g
// - user states active stream count
// - receiver finds stream count itself
// - word clock rate set by mode
// - stream enables follow per-mode cadence
module ussmc_dev import ussmc_pkg::*; #(
  parameter int RATE_TICKS = `USSMC_RATE_TICKS
) (
  input wire logic clock,
  input wire logic rst_n,
  ussmc_if.dev link,
  output logic [`USSMC_GT_W-1:0] gt_txdata,
  input wire logic [`USSMC_GT_W-1:0] gt_rxdata,
  input wire logic gt_rxvalid,
  output logic gt_tx_wide,
  output logic gt_rx_wide,
  output logic [2:0] gt_tx_div,
  output logic [2:0] gt_rx_div,
  output logic gt_tx_refsel,
  output logic gt_rx_refsel,
  output logic gt_reset,
  input wire logic gt_reset_done,
  input wire logic ref_tick
);
  typedef enum logic [2:0] {
    RS_HOLD = 3'h1,
    RS_WAIT = 3'h2,
    RS_RUN = 3'h4
  } ussmc_rst_t;

  localparam int WW = `USSMC_WORD_W;
  ussmc_rst_t rst_st_r;
  logic [7:0] rst_cnt_r;
  ussmc_mode_t txm_r;
  ussmc_mode_t rxm_r;
  logic run;
  ussmc_set_t fifo_data;
  logic fifo_valid;
  logic pop;
  logic [4:0] tx_n;
  logic [2:0] tx_w;
  logic [3:0] slot_r;
  logic [3:0] slot_nxt;
  logic [6:0] sp_r;
  logic [6:0] sp_nxt;
  logic [WW-1:0] sd_cur_r;
  logic [`USSMC_GT_W-1:0] txd;
  logic [9:0] acc_r;
  logic [9:0] acc_nxt;
  logic [3:0] dcnt_r;
  logic [3:0] dcnt_nxt;
  logic [3:0] pos_r;
  logic dru_emit;
  logic [WW-1:0] dru_word;
  logic [4:0] run_r;
  logic [4:0] run_nxt;
  logic [3:0] rslot_r;
  logic [3:0] rslot_nxt;
  ussmc_mux_t nlog_r;
  ussmc_mux_t nlog_nxt;
  ussmc_set_t col_r;
  ussmc_set_t col_nxt;
  ussmc_set_t oset;
  logic emit;
  logic [15:0] tick_cnt_r;
  logic [15:0] word_cnt_r;

  // trs run length to stream count; top bit flags a legal count
  function automatic logic [3:0] trs_log(input logic [4:0] r);
    case (r)
      5'h01: return 4'h8;
      5'h02: return 4'h9;
      5'h04: return 4'hA;
      5'h08: return 4'hB;
      5'h10: return 4'hC;
      default: return 4'h0;
    endcase
  endfunction

  // hold the gt in reset after power-up or any mode change
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_st_r <= RS_HOLD;
      rst_cnt_r <= 8'h00;
      gt_reset <= 1'b1;
      txm_r <= USSMC_MODE_SD;
      rxm_r <= USSMC_MODE_SD;
    end
    else
    begin
      txm_r <= link.tx_mode;
      rxm_r <= link.rx_mode;
      if (link.tx_mode != txm_r || link.rx_mode != rxm_r)
      begin
        rst_st_r <= RS_HOLD;
        rst_cnt_r <= 8'h00;
        gt_reset <= 1'b1;
      end
      else
        case (rst_st_r)
          RS_HOLD:
            if (rst_cnt_r == 8'(`USSMC_GT_RST_CYC - 1))
            begin
              rst_st_r <= RS_WAIT;
              gt_reset <= 1'b0;
            end
            else
              rst_cnt_r <= rst_cnt_r + 8'h01;
          RS_WAIT:
            if (gt_reset_done)
              rst_st_r <= RS_RUN;
          RS_RUN:
            if (!gt_reset_done)
            begin
              rst_st_r <= RS_HOLD;
              rst_cnt_r <= 8'h00;
              gt_reset <= 1'b1;
            end
          default:
            rst_st_r <= RS_HOLD;
        endcase
    end
  end

  assign run = rst_st_r == RS_RUN;

  // per-mode port width and serial divider, and the tx reference select
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gt_tx_wide <= 1'b0;
      gt_rx_wide <= 1'b0;
      gt_tx_div <= `USSMC_DIV_3G;
      gt_rx_div <= `USSMC_DIV_3G;
      gt_tx_refsel <= 1'b0;
    end
    else
    begin
      gt_tx_wide <= ussmc_is_wide(txm_r);
      gt_rx_wide <= ussmc_is_wide(rxm_r);
      gt_tx_div <= ussmc_div(txm_r);
      gt_rx_div <= ussmc_div(rxm_r);
      gt_tx_refsel <= link.tx_frac && (txm_r != USSMC_MODE_SD);
    end
  end

  ussmc_fifo #(
    .WIDTH($bits(ussmc_set_t)),
    .DEPTH(`USSMC_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_data(link.tx_set),
    .in_valid(link.tx_valid),
    .in_ready(link.tx_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop && run)
  );

  assign tx_n = (txm_r == USSMC_MODE_SD) ? 5'h01 : ussmc_nstreams(link.tx_mux);
  assign tx_w = ussmc_is_wide(txm_r) ? 3'(`USSMC_WIDE_WORDS) : 3'(`USSMC_NARROW_WORDS);

  always_comb
  begin
    int k;
    k = 0;
    txd = '0;
    pop = 1'b0;
    slot_nxt = slot_r;
    sp_nxt = sp_r;
    if (txm_r == USSMC_MODE_SD)
    begin
      // each bit repeated eleven times, 110 bits per word
      for (int i = 0; i < `USSMC_NARROW_BITS; i++)
      begin
        k = int'(sp_r) + i;
        if (k < `USSMC_SD_FRAME)
          txd[i] = sd_cur_r[k / `USSMC_SD_OVS];
        else
          txd[i] = fifo_valid & fifo_data[0][(k - `USSMC_SD_FRAME) / `USSMC_SD_OVS];
      end
      if (int'(sp_r) + `USSMC_NARROW_BITS >= `USSMC_SD_FRAME)
      begin
        pop = 1'b1;
        sp_nxt = 7'(int'(sp_r) + `USSMC_NARROW_BITS - `USSMC_SD_FRAME);
      end
      else
        sp_nxt = 7'(int'(sp_r) + `USSMC_NARROW_BITS);
    end
    else
    begin
      for (int i = 0; i < `USSMC_WIDE_WORDS; i++)
        if (i < int'(tx_w) && fifo_valid)
          txd[i*WW +: WW] = fifo_data[(slot_r + 4'(i)) & 4'(tx_n - 5'h01)];
      if (5'(slot_r) + 5'(tx_w) >= tx_n)
      begin
        pop = 1'b1;
        slot_nxt = 4'h0;
      end
      else if (fifo_valid)
        slot_nxt = slot_r + 4'(tx_w);
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slot_r <= 4'h0;
      sp_r <= 7'h00;
      sd_cur_r <= '0;
      gt_txdata <= '0;
      link.tx_ce <= 1'b0;
    end
    else if (!run)
    begin
      slot_r <= 4'h0;
      sp_r <= 7'h00;
      gt_txdata <= '0;
      link.tx_ce <= 1'b0;
    end
    else
    begin
      slot_r <= slot_nxt;
      sp_r <= sp_nxt;
      gt_txdata <= txd;
      link.tx_ce <= pop && fifo_valid;
      if (pop)
        sd_cur_r <= fifo_valid ? fifo_data[0] : '0;
    end
  end

  // sd recovery: one sample per eleven bits at a fixed phase
  always_comb
  begin
    acc_nxt = acc_r;
    dcnt_nxt = dcnt_r;
    dru_emit = 1'b0;
    dru_word = '0;
    for (int i = 0; i < `USSMC_NARROW_BITS; i++)
      if ((int'(pos_r) + i) % `USSMC_SD_OVS == `USSMC_SD_PHASE)
      begin
        acc_nxt = {gt_rxdata[i], acc_nxt[9:1]};
        dcnt_nxt = dcnt_nxt + 4'h1;
        if (dcnt_nxt == 4'(WW))
        begin
          dru_emit = 1'b1;
          dru_word = acc_nxt;
          dcnt_nxt = 4'h0;
        end
      end
  end

  // stream count from the length of the 3FF run of a trs
  always_comb
  begin
    int nw;
    logic [WW-1:0] w;
    logic [3:0] lg;
    nw = 0;
    w = '0;
    lg = 4'h0;
    run_nxt = run_r;
    rslot_nxt = rslot_r;
    nlog_nxt = nlog_r;
    col_nxt = col_r;
    oset = col_r;
    emit = 1'b0;
    if (rxm_r == USSMC_MODE_SD)
      nw = (gt_rxvalid && dru_emit) ? 1 : 0;
    else if (!gt_rxvalid)
      nw = 0;
    else
      nw = ussmc_is_wide(rxm_r) ? `USSMC_WIDE_WORDS : `USSMC_NARROW_WORDS;
    for (int i = 0; i < `USSMC_WIDE_WORDS; i++)
      if (i < nw)
      begin
        w = (rxm_r == USSMC_MODE_SD) ? dru_word : gt_rxdata[i*WW +: WW];
        lg = trs_log(run_nxt);
        if (w == `USSMC_TRS_ONES)
        begin
          if (run_nxt != 5'h10)
            run_nxt = run_nxt + 5'h01;
        end
        else
        begin
          if (w == `USSMC_TRS_ZERO && lg[3])
          begin
            nlog_nxt = ussmc_mux_t'(lg[2:0]);
            rslot_nxt = 4'h0;
          end
          run_nxt = 5'h00;
        end
        col_nxt[rslot_nxt] = w;
        if (5'(rslot_nxt) == ussmc_nstreams(nlog_nxt) - 5'h01)
        begin
          emit = 1'b1;
          oset = col_nxt;
          rslot_nxt = 4'h0;
        end
        else
          rslot_nxt = rslot_nxt + 4'h1;
      end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_r <= '0;
      dcnt_r <= 4'h0;
      pos_r <= 4'h0;
      run_r <= 5'h00;
      rslot_r <= 4'h0;
      nlog_r <= USSMC_MUX_1;
      col_r <= '0;
      link.rx_set <= '0;
      link.rx_valid <= 1'b0;
      link.rx_count <= USSMC_MUX_1;
    end
    else if (!run)
    begin
      run_r <= 5'h00;
      rslot_r <= 4'h0;
      link.rx_valid <= 1'b0;
    end
    else
    begin
      if (gt_rxvalid && rxm_r == USSMC_MODE_SD)
      begin
        acc_r <= acc_nxt;
        dcnt_r <= dcnt_nxt;
        pos_r <= 4'((int'(pos_r) + `USSMC_NARROW_BITS) % `USSMC_SD_OVS);
      end
      run_r <= run_nxt;
      rslot_r <= rslot_nxt;
      nlog_r <= nlog_nxt;
      col_r <= col_nxt;
      link.rx_valid <= emit;
      link.rx_count <= nlog_nxt;
      if (emit)
        link.rx_set <= oset;
    end
  end

  // received words per window of integer-reference ticks
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_r <= 16'h0000;
      word_cnt_r <= 16'h0000;
      link.rx_frac <= 1'b0;
      gt_rx_refsel <= 1'b0;
    end
    else if (ref_tick && tick_cnt_r == 16'(RATE_TICKS - 1))
    begin
      tick_cnt_r <= 16'h0000;
      word_cnt_r <= 16'h0000;
      link.rx_frac <= word_cnt_r < 16'(RATE_TICKS - `USSMC_RATE_TOL);
      gt_rx_refsel <= word_cnt_r < 16'(RATE_TICKS - `USSMC_RATE_TOL);
    end
    else
    begin
      if (ref_tick)
        tick_cnt_r <= tick_cnt_r + 16'h0001;
      if (gt_rxvalid && word_cnt_r != 16'hFFFF)
        word_cnt_r <= word_cnt_r + 16'h0001;
    end
  end
endmodule

// File: src/ussmc_usr.sv
// user end: maps video sets onto elementary streams and back
module ussmc_usr import ussmc_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  ussmc_if.usr link,
  input wire ussmc_mode_t cfg_tx_mode,
  input wire logic cfg_tx_frac,
  input wire ussmc_mux_t cfg_tx_mux,
  input wire logic cfg_tx_mapped,
  input wire ussmc_mode_t cfg_rx_mode,
  input wire logic cfg_rx_mapped,
  input wire ussmc_set_t vid_in_set,
  input wire logic vid_in_valid,
  output logic vid_in_ready,
  output ussmc_set_t vid_out_set,
  output logic vid_out_valid,
  output ussmc_mux_t vid_out_count,
  output logic vid_out_frac
);
  logic take;

  // mapped formats spread neighbours over links by bit-reversed index
  function automatic ussmc_set_t remap(input ussmc_set_t s, input ussmc_mux_t m,
                                       input logic mapped);
    logic [3:0] r;
    logic [3:0] rv;
    ussmc_set_t o;
    o = s;
    for (int i = 0; i < 16; i++)
    begin
      r = 4'(i);
      rv = {r[0], r[1], r[2], r[3]} >> (3'h4 - 3'(m));
      if (mapped && 5'(i) < ussmc_nstreams(m))
        o[i] = s[rv];
    end
    return o;
  endfunction

  assign vid_in_ready = !link.tx_valid || link.tx_ready;
  assign take = vid_in_valid && vid_in_ready;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.tx_mode <= USSMC_MODE_SD;
      link.tx_frac <= 1'b0;
      link.tx_mux <= USSMC_MUX_1;
      link.rx_mode <= USSMC_MODE_SD;
    end
    else
    begin
      link.tx_mode <= cfg_tx_mode;
      link.tx_frac <= cfg_tx_frac;
      link.tx_mux <= (cfg_tx_mode == USSMC_MODE_SD) ? USSMC_MUX_1 : cfg_tx_mux;
      link.rx_mode <= cfg_rx_mode;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.tx_set <= '0;
      link.tx_valid <= 1'b0;
    end
    else if (take)
    begin
      link.tx_set <= remap(vid_in_set, cfg_tx_mux, cfg_tx_mapped);
      link.tx_valid <= 1'b1;
    end
    else if (link.tx_ready)
      link.tx_valid <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vid_out_set <= '0;
      vid_out_valid <= 1'b0;
      vid_out_count <= USSMC_MUX_1;
      vid_out_frac <= 1'b0;
    end
    else
    begin
      vid_out_valid <= link.rx_valid;
      vid_out_count <= link.rx_count;
      vid_out_frac <= link.rx_frac;
      if (link.rx_valid)
        vid_out_set <= remap(link.rx_set, link.rx_count, cfg_rx_mapped);
    end
  end
endmodule

// File: verification/ussmc_monitor.sv
// link-side checks between the device end and the user end
module ussmc_monitor import ussmc_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire ussmc_mode_t tx_mode,
  input wire ussmc_mux_t tx_mux,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_ce,
  input wire ussmc_mode_t rx_mode,
  input wire ussmc_set_t rx_set,
  input wire logic rx_valid,
  input wire ussmc_mux_t rx_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_sd_one_mux;
    tx_mode == USSMC_MODE_SD |-> tx_mux == USSMC_MUX_1;
  endproperty
  a_sd_one_mux: assert property (p_sd_one_mux)
    else $error("sd mode with more than one stream");

  property p_sixteen_12g;
    tx_mux == USSMC_MUX_16 |-> tx_mode == USSMC_MODE_12G;
  endproperty
  a_sixteen_12g: assert property (p_sixteen_12g)
    else $error("sixteen streams outside 12g");

  property p_sd_cadence;
    tx_ce && tx_mode == USSMC_MODE_SD |=> !tx_ce [*4];
  endproperty
  a_sd_cadence: assert property (p_sd_cadence)
    else $error("sd enable gap below five");

  property p_quad_cadence;
    tx_ce && tx_mux == USSMC_MUX_16 |=> !tx_ce [*3];
  endproperty
  a_quad_cadence: assert property (p_quad_cadence)
    else $error("sixteen stream enable gap below four");

  property p_half_cadence;
    tx_ce && tx_mode == USSMC_MODE_3GB |=> !tx_ce;
  endproperty
  a_half_cadence: assert property (p_half_cadence)
    else $error("level b enable gap below two");

  property p_rx_hold;
    !rx_valid |-> $stable(rx_set);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("rx set moved without valid");

  property p_sd_rx_single;
    rx_valid && rx_mode == USSMC_MODE_SD |-> rx_count == USSMC_MUX_1;
  endproperty
  a_sd_rx_single: assert property (p_sd_rx_single)
    else $error("sd receive count not single");

  property p_rx_count_legal;
    rx_valid |-> rx_count <= USSMC_MUX_16;
  endproperty
  a_rx_count_legal: assert property (p_rx_count_legal)
    else $error("rx stream count out of range");

  property p_ready_holds;
    tx_ready && !tx_valid |=> tx_ready;
  endproperty
  a_ready_holds: assert property (p_ready_holds)
    else $error("fifo filled without a push");
endmodule

// File: verification/tb_uhd_sdi_stream_mode_control.sv
// bench: user end and device end on one link, transceiver looped back
`include "ussmc_params.svh"
module tb_uhd_sdi_stream_mode_control import ussmc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RT = 64;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [`USSMC_GT_W-1:0] gt_txdata;
  logic gt_tx_wide, gt_rx_wide, gt_tx_refsel, gt_rx_refsel, gt_reset;
  logic [2:0] gt_tx_div, gt_rx_div;
  logic gt_rxvalid = 1'b0;
  logic gt_reset_done = 1'b0;
  logic ref_tick = 1'b0;
  ussmc_mode_t cfg_mode = USSMC_MODE_SD;
  ussmc_mux_t cfg_mux = USSMC_MUX_1;
  logic cfg_frac = 1'b0;
  logic cfg_mapped = 1'b0;
  ussmc_set_t vid_in_set = '0;
  logic vid_in_valid = 1'b0;
  logic vid_in_ready, vid_out_valid, vid_out_frac;
  ussmc_set_t vid_out_set;
  ussmc_mux_t vid_out_count;
  logic hold_done = 1'b0;
  logic drop = 1'b0;
  logic [1:0] ph = 2'h0;
  logic rx_up = 1'b0;
  int n_fail = 0;
  int n_compared = 0;
  int n_ce = 0;
  ussmc_set_t rxq[$];
  ussmc_mode_t tm[8] = '{USSMC_MODE_SD, USSMC_MODE_HD, USSMC_MODE_3GA, USSMC_MODE_3GB,
    USSMC_MODE_6G, USSMC_MODE_6G, USSMC_MODE_12G, USSMC_MODE_12G};
  ussmc_mux_t tx[8] = '{USSMC_MUX_1, USSMC_MUX_2, USSMC_MUX_2, USSMC_MUX_4,
    USSMC_MUX_4, USSMC_MUX_8, USSMC_MUX_8, USSMC_MUX_16};

  ussmc_if lnk ();
  ussmc_dev #(.RATE_TICKS(RT)) ussmc_dev_i (.clock(clock), .rst_n(rst_n), .link(lnk.dev),
    .gt_txdata(gt_txdata), .gt_rxdata(gt_txdata), .gt_rxvalid(gt_rxvalid),
    .gt_tx_wide(gt_tx_wide), .gt_rx_wide(gt_rx_wide), .gt_tx_div(gt_tx_div),
    .gt_rx_div(gt_rx_div), .gt_tx_refsel(gt_tx_refsel), .gt_rx_refsel(gt_rx_refsel),
    .gt_reset(gt_reset), .gt_reset_done(gt_reset_done), .ref_tick(ref_tick));
  ussmc_usr ussmc_usr_i (.clock(clock), .rst_n(rst_n), .link(lnk.usr),
    .cfg_tx_mode(cfg_mode), .cfg_tx_frac(cfg_frac), .cfg_tx_mux(cfg_mux),
    .cfg_tx_mapped(cfg_mapped), .cfg_rx_mode(cfg_mode), .cfg_rx_mapped(cfg_mapped),
    .vid_in_set(vid_in_set), .vid_in_valid(vid_in_valid), .vid_in_ready(vid_in_ready),
    .vid_out_set(vid_out_set), .vid_out_valid(vid_out_valid),
    .vid_out_count(vid_out_count), .vid_out_frac(vid_out_frac));
  ussmc_monitor ussmc_monitor_i (.clock(clock), .rst_n(rst_n), .tx_mode(lnk.tx_mode),
    .tx_mux(lnk.tx_mux), .tx_valid(lnk.tx_valid), .tx_ready(lnk.tx_ready),
    .tx_ce(lnk.tx_ce), .rx_mode(lnk.rx_mode), .rx_set(lnk.rx_set),
    .rx_valid(lnk.rx_valid), .rx_count(lnk.rx_count));

  initial
  begin
    forever #4 clock = ~clock;
  end

  // transceiver stand-in: done after reset, words valid from the first sent word,
  // optional rate loss; sd framing depends on rx starting with that word
  always @(negedge clock)
  begin
    ph <= ph + 2'h1;
    ref_tick <= 1'b1;
    gt_reset_done <= !gt_reset && !hold_done;
    rx_up <= !gt_reset && gt_reset_done;
    gt_rxvalid <= !gt_reset && rx_up && !(drop && ph == 2'h0);
  end

  always @(posedge clock)
  begin
    if (lnk.tx_ce === 1'b1) n_ce <= n_ce + 1;
    if (vid_out_valid === 1'b1) rxq.push_back(vid_out_set);
  end

  task automatic chk(input string what, input logic [159:0] seen, input logic [159:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic push(input ussmc_set_t s, input int bound, output bit ok);
    vid_in_set = s;
    vid_in_valid = 1'b1;
    ok = 1'b0;
    for (int i = 0; i < bound && !ok; i++)
    begin
      if (vid_in_ready === 1'b1) ok = 1'b1;
      @(negedge clock);
    end
  endtask

  task automatic wait_run();
    int i;
    repeat (4) @(negedge clock);
    for (i = 0; i < 400 && gt_rxvalid !== 1'b1; i++) @(negedge clock);
    if (i == 400)
    begin
      $display("Error link never came up");
      n_fail++;
      summarize();
    end
  endtask

  function automatic ussmc_set_t mkset(input int j);
    ussmc_set_t s;
    for (int k = 0; k < 16; k++) s[k] = 10'h100 + 10'(j * 16 + k);
    return s;
  endfunction

  function automatic ussmc_set_t msk(input ussmc_set_t s, input int n);
    for (int k = n; k < 16; k++) s[k] = '0;
    return s;
  endfunction

  function automatic logic [2:0] xdiv(input ussmc_mode_t m);
    case (m)
      USSMC_MODE_HD: return `USSMC_DIV_HD;
      USSMC_MODE_6G: return `USSMC_DIV_6G;
      USSMC_MODE_12G: return `USSMC_DIV_12G;
      default: return `USSMC_DIV_3G;
    endcase
  endfunction

  initial
  begin
    int n, hi, acc;
    bit ok, found, wide;
    ussmc_set_t e1, e2;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (`USSMC_GT_RST_CYC - 2) @(negedge clock);
    chk("gt_reset held", gt_reset, 1'b1);
    repeat (5) @(negedge clock);
    chk("gt_reset released", gt_reset, 1'b0);
    $display("test reset sequence done");
    for (int t = 0; t < 8; t++)
    begin
      n = 1 << tx[t];
      wide = tm[t] inside {USSMC_MODE_6G, USSMC_MODE_12G};
      cfg_mode = tm[t];
      cfg_mux = tx[t];
      cfg_frac = t[0];
      cfg_mapped = t[1];
      wait_run();
      chk("tx wide", gt_tx_wide, wide);
      chk("rx wide", gt_rx_wide, wide);
      chk("tx div", gt_tx_div, xdiv(tm[t]));
      chk("rx div", gt_rx_div, xdiv(tm[t]));
      chk("tx refsel", gt_tx_refsel, t[0] && tm[t] != USSMC_MODE_SD);
      rxq.delete();
      e1 = mkset(2 * t);
      e2 = mkset(2 * t + 1);
      push('1, 8, ok);
      push('0, 8, ok);
      push(e1, 8, ok);
      push(e2, 8, ok);
      vid_in_valid = 1'b0;
      repeat (300) @(negedge clock);
      found = 1'b0;
      hi = 0;
      for (int i = 0; i + 1 < rxq.size(); i++)
        if (!found && rxq[i][0] === e1[0])
        begin
          found = 1'b1;
          hi = i;
        end
      chk("set found", found, 1'b1);
      chk("first set", msk(rxq[hi], n), msk(e1, n));
      chk("second set", msk(rxq[hi + 1], n), msk(e2, n));
      chk("stream count", vid_out_count, tx[t]);
      $display("test mode %0d with %0d streams done", t, n);
    end
    hold_done = 1'b1;
    repeat (10) @(negedge clock);
    acc = 0;
    ok = 1'b1;
    while (ok && acc < 40)
    begin
      push(mkset(acc), 3, ok);
      if (ok) acc++;
    end
    vid_in_valid = 1'b0;
    chk("sets taken", acc, 33);
    chk("fifo full", lnk.tx_ready, 1'b0);
    n_ce = 0;
    hold_done = 1'b0;
    for (int i = 0; i < 600 && n_ce < 33; i++) @(negedge clock);
    chk("sets drained", n_ce, 33);
    $display("test fifo fill and drain done");
    drop = 1'b1;
    repeat (4 * RT) @(negedge clock);
    chk("fractional seen", vid_out_frac, 1'b1);
    chk("rx refsel", gt_rx_refsel, 1'b1);
    drop = 1'b0;
    repeat (4 * RT) @(negedge clock);
    chk("integer seen", vid_out_frac, 1'b0);
    chk("rx refsel", gt_rx_refsel, 1'b0);
    $display("test rate detect done");
    summarize();
  end
endmodule
